// File: design/udt_timing_ctrl.v
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "udt_regs.vh"
module udt_timing_ctrl (
  input  wire        I_CLOCK,
  input  wire        I_RESET_N,
  input  wire        I_HSEL,
  input  wire [11:0] I_HADDR,
  input  wire [1:0]  I_HTRANS,
  input  wire        I_HWRITE,
  input  wire [2:0]  I_HSIZE,
  input  wire [31:0] I_HWDATA,
  input  wire        I_HREADY,
  input  wire        I_SETFEAT_UDMA,
  input  wire        I_SLAVE_BUSY,
  input  wire        I_MASTER_BUSY,
  output reg  [31:0] O_HRDATA,
  output reg         O_HREADYOUT,
  output reg         O_HRESP,
  output reg         O_SLAVE_UDMA_EN,
  output reg         O_SLAVE_PIO_MODE,
  output reg  [2:0]  O_SLAVE_CYCLE_CLKS,
  output reg  [2:0]  O_MASTER_CYCLE_CLKS
);
  ////////////////////////////////////////////////////////////////////
  // address decode and field helpers
  function is_ctrl;
    input [11:0] addr;
    begin
      is_ctrl = (addr == `UDT_CTRL_OFFSET);
    end
  endfunction

  function is_stat;
    input [11:0] addr;
    begin
      is_stat = (addr == `UDT_STAT_OFFSET);
    end
  endfunction

  // only writable bits survive, reserved bits stay zero
  function [31:0] ctrl_view;
    input [31:0] raw;
    begin
      ctrl_view = raw & `UDT_WMASK;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for drive-side pins
  reg  [1:0] sf_sync_q;
  reg  [1:0] sb_sync_q;
  reg  [1:0] mb_sync_q;
  wire       setfeat;
  wire       sbusy;
  wire       mbusy;

  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sf_sync_q <= 2'h0;
      sb_sync_q <= 2'h0;
      mb_sync_q <= 2'h0;
    end else begin
      sf_sync_q <= {sf_sync_q[0], I_SETFEAT_UDMA};
      sb_sync_q <= {sb_sync_q[0], I_SLAVE_BUSY};
      mb_sync_q <= {mb_sync_q[0], I_MASTER_BUSY};
    end
  end

  assign setfeat = sf_sync_q[1];
  assign sbusy   = sb_sync_q[1];
  assign mbusy   = mb_sync_q[1];

  ////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture
  reg         wr_pend_q;
  reg         wr_pend_d;
  reg  [11:0] addr_q;
  reg  [11:0] addr_d;
  wire        take;
  wire        rd_take;

  assign take    = I_HSEL & I_HREADY & I_HTRANS[1];
  assign rd_take = take & ~I_HWRITE;

  always @* begin
    wr_pend_d = take & I_HWRITE;
    addr_d    = addr_q;
    if (take) begin
      addr_d = I_HADDR;
    end
  end

  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else begin
      wr_pend_q <= wr_pend_d;
      addr_q    <= addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control register
  reg  [31:0] ctrl_q;
  reg  [31:0] ctrl_d;
  wire        ctrl_wr;
  wire [31:0] ctrl_now;

  assign ctrl_wr  = wr_pend_q & is_ctrl(addr_q);
  // a read right behind a write sees the new value
  assign ctrl_now = ctrl_wr ? ctrl_view(I_HWDATA) : ctrl_q;

  always @* begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = ctrl_view(I_HWDATA);
    end
  end

  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_q <= `UDT_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data and response
  reg  [31:0] rdata_d;
  wire [31:0] stat_rd;

  assign stat_rd = {24'h00_0000, O_SLAVE_CYCLE_CLKS, O_MASTER_CYCLE_CLKS,
                    O_SLAVE_PIO_MODE, O_SLAVE_UDMA_EN};

  // read data stands until the next read is taken
  always @* begin
    rdata_d = O_HRDATA;
    if (rd_take) begin
      if (is_ctrl(I_HADDR)) begin
        rdata_d = ctrl_now;
      end else if (is_stat(I_HADDR)) begin
        rdata_d = stat_rd;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_HRDATA    <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end else begin
      O_HRDATA    <= rdata_d;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // effective drive settings
  wire       method;
  wire       en_eff;
  wire [1:0] scode;
  wire [1:0] mcode;
  wire [2:0] sclk;
  wire [2:0] mclk;

  assign method = ctrl_q[`UDT_METHOD_BIT];
  assign en_eff = method ? ctrl_q[`UDT_ENABLE_BIT] : setfeat;
  assign scode  = ctrl_q[`UDT_SCYC_LSB+1:`UDT_SCYC_LSB];
  assign mcode  = ctrl_q[`UDT_MCYC_LSB+1:`UDT_MCYC_LSB];

  udt_cycle_len u_scyc (
    .i_code   (scode),
    .o_clocks (sclk)
  );

  udt_cycle_len u_mcyc (
    .i_code   (mcode),
    .o_clocks (mclk)
  );

  ////////////////////////////////////////////////////////////////////
  // outputs latched only while the drive is idle
  // busy is seen two clocks late, so a setting may move in that gap
  reg       slv_en_d;
  reg       slv_pio_d;
  reg [2:0] slv_clks_d;
  reg [2:0] mst_clks_d;

  always @* begin
    slv_en_d   = O_SLAVE_UDMA_EN;
    slv_pio_d  = O_SLAVE_PIO_MODE;
    slv_clks_d = O_SLAVE_CYCLE_CLKS;
    mst_clks_d = O_MASTER_CYCLE_CLKS;
    if (!sbusy) begin
      slv_en_d   = en_eff;
      slv_pio_d  = ctrl_q[`UDT_XMODE_BIT];
      slv_clks_d = sclk;
    end
    if (!mbusy) begin
      mst_clks_d = mclk;
    end
  end

  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SLAVE_UDMA_EN     <= 1'b0;
      O_SLAVE_PIO_MODE    <= 1'b0;
      O_SLAVE_CYCLE_CLKS  <= `UDT_CLKS_RESET;
      O_MASTER_CYCLE_CLKS <= `UDT_CLKS_RESET;
    end else begin
      O_SLAVE_UDMA_EN     <= slv_en_d;
      O_SLAVE_PIO_MODE    <= slv_pio_d;
      O_SLAVE_CYCLE_CLKS  <= slv_clks_d;
      O_MASTER_CYCLE_CLKS <= mst_clks_d;
    end
  end

endmodule

// File: design/udt_regs.vh
`ifndef UDT_REGS_VH
`define UDT_REGS_VH
`define UDT_CTRL_OFFSET   12'h000
`define UDT_STAT_OFFSET   12'h004
`define UDT_METHOD_BIT    7
`define UDT_ENABLE_BIT    6
`define UDT_XMODE_BIT     5
`define UDT_SCYC_LSB      0
`define UDT_MCYC_LSB      8
`define UDT_WMASK         32'h0000_03E3
`define UDT_CTRL_RESET    32'h0000_0303
`define UDT_CYC_RESET     2'h3
`define UDT_CLKS_RESET    3'h5
`endif

// File: design/udt_cycle_len.v
`timescale 1ns/10ps
`include "udt_regs.vh"
module udt_cycle_len (
  input  wire [1:0] i_code,
  output wire [2:0] o_clocks
);
  assign o_clocks = {1'b0, i_code} + 3'h2;
endmodule

// File: tb/udt_timing_monitor.sv
`timescale 1ns/10ps
module udt_timing_monitor (
  input wire       I_CLOCK,
  input wire       I_RESET_N,
  input wire       I_SLAVE_BUSY,
  input wire       I_MASTER_BUSY,
  input wire       O_HREADYOUT,
  input wire       O_HRESP,
  input wire       O_SLAVE_UDMA_EN,
  input wire       O_SLAVE_PIO_MODE,
  input wire [2:0] O_SLAVE_CYCLE_CLKS,
  input wire [2:0] O_MASTER_CYCLE_CLKS
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  a_slave_range: assert property (O_SLAVE_CYCLE_CLKS inside {[3'h2:3'h5]})
    else $error("slave cycle out of range");
  a_master_range: assert property (O_MASTER_CYCLE_CLKS inside {[3'h2:3'h5]})
    else $error("master cycle out of range");
  a_slave_hold: assert property (I_SLAVE_BUSY [*4] |=> $stable({O_SLAVE_UDMA_EN, O_SLAVE_PIO_MODE, O_SLAVE_CYCLE_CLKS}))
    else $error("slave setting changed mid transfer");
  a_master_hold: assert property (I_MASTER_BUSY [*4] |=> $stable(O_MASTER_CYCLE_CLKS))
    else $error("master setting changed mid transfer");
  a_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus not ready or error response");
  a_reset_values: assert property ($rose(I_RESET_N) |->
    {O_SLAVE_UDMA_EN, O_SLAVE_PIO_MODE, O_SLAVE_CYCLE_CLKS, O_MASTER_CYCLE_CLKS} == 8'h2D)
    else $error("outputs not at reset values after reset");
endmodule
bind udt_timing_ctrl udt_timing_monitor i_mon (.I_CLOCK, .I_RESET_N, .I_SLAVE_BUSY, .I_MASTER_BUSY, .O_HREADYOUT,
  .O_HRESP, .O_SLAVE_UDMA_EN, .O_SLAVE_PIO_MODE, .O_SLAVE_CYCLE_CLKS, .O_MASTER_CYCLE_CLKS);

// File: tb/udt_drive_model.sv
`timescale 1ns/10ps
module udt_drive_model (
  input wire   i_clk, input wire i_start, input wire i_sf,
  output logic o_busy = 0,
  output logic o_sf = 0
);
  int n = 0;
  // drive reports set-feature state and a 40-cycle transfer
  always @(posedge i_clk) begin
    o_sf <= i_sf;
    if (i_start && n == 0) n <= 40; else if (n > 0) n <= n - 1;
    o_busy <= (n > 1) || (i_start && n == 0);
  end
endmodule

// File: tb/udt_timing_ctrl_tb_top.sv
`timescale 1ns/10ps
module udt_timing_ctrl_tb_top;
  logic clk = 0, rn = 0, sel = 0, wr = 0, sf = 0, go = 0, mb = 0, busy, sfo, en, pio, rdy;
  logic [1:0] tr = 0;
  logic [11:0] a = 0;
  logic [31:0] wd = 0, rd, r;
  logic [2:0] mc, sc;
  int error_cnt = 0, compares = 0;
  wire [31:0] obs = {24'h0, en, pio, mc, sc};
  always #4 clk = ~clk;
  udt_drive_model i_drv (.i_clk(clk), .i_start(go), .i_sf(sf), .o_busy(busy), .o_sf(sfo));
  udt_timing_ctrl i_dut (.I_CLOCK(clk), .I_RESET_N(rn), .I_HSEL(sel), .I_HADDR(a), .I_HTRANS(tr), .I_HWRITE(wr),
    .I_HSIZE(3'h2), .I_HWDATA(wd), .I_HREADY(rdy), .I_SETFEAT_UDMA(sfo), .I_SLAVE_BUSY(busy), .I_MASTER_BUSY(mb),
    .O_HRDATA(rd), .O_HREADYOUT(rdy), .O_HRESP(), .O_SLAVE_UDMA_EN(en), .O_SLAVE_PIO_MODE(pio),
    .O_SLAVE_CYCLE_CLKS(sc), .O_MASTER_CYCLE_CLKS(mc));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk); sel <= 1; tr <= 2'h2; wr <= w; a <= ad;
    do @(posedge clk); while (rdy !== 1'b1);
    tr <= 2'h0; sel <= 0; wd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rd;
  endtask
  task automatic w6; repeat (6) @(posedge clk); endtask
  task automatic end_of_test;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS"); else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_rst;
    bus(0, 12'h000, 32'h0); chk(r, 32'h0000_0303);
    chk(obs, 32'h0000_002D);
    bus(0, 12'h004, 32'h0);
    chk(r, 32'h0000_00B4);
    $display("t_rst done");
  endtask
  task automatic t_codes;
    logic [31:0] d;
    for (int c = 0; c < 4; c++) begin
      d = 32'h0000_00DC | (c << 8) | c | ((c & 1) << 5);
      bus(1, 12'h000, d); bus(0, 12'h000, 32'h0); chk(r, d & 32'h0000_03E3);
      w6; chk(obs, {24'h0, 1'b1, d[5], d[1:0] + 3'h2, d[1:0] + 3'h2});
      chk(pio, d[5]);
    end
    bus(0, 12'h008, 32'h0); chk(r, 32'h0);
    $display("t_codes done");
  endtask
  task automatic t_sf;
    bus(1, 12'h000, 32'h0000_0040); w6; chk(en, 1'b0);
    sf <= 1; w6; chk(en, 1'b1);
    bus(1, 12'h000, 32'h0000_0080); w6; chk(obs, 32'h0000_0012);
    $display("t_sf done");
  endtask
  task automatic t_busy;
    go <= 1; mb <= 1; @(posedge clk); go <= 0; repeat (4) @(posedge clk);
    bus(1, 12'h000, 32'h0000_03E3); w6; chk(obs, 32'h0000_0012);
    mb <= 0;
    for (int k = 0; k < 100 && busy; k++) @(posedge clk);
    w6; chk(obs, 32'h0000_00ED);
    $display("t_busy done");
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge clk); rn <= 1;
    t_rst; t_codes; t_sf; t_busy;
    end_of_test;
  end
endmodule
